/* File: rtl/tpci_pkg.sv */
// shared constants and carrier types of the timer, pwm, capture and ir block
package tpci_pkg;
   localparam int CH_N = 5;
   localparam int CNT_W = 16;
   localparam int T8_W = 8;
   localparam int ST_W = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PRESC = 8'h04;
   localparam logic [7:0] OFF_PERIOD = 8'h08;
   localparam logic [7:0] OFF_COUNT = 8'h0C;
   localparam logic [7:0] OFF_CH0 = 8'h10;
   localparam logic [7:0] OFF_CH_STEP = 8'h04;
   localparam logic [7:0] OFF_T8A_CTRL = 8'h24;
   localparam logic [7:0] OFF_T8A_CFG = 8'h28;
   localparam logic [7:0] OFF_T8B_CTRL = 8'h2C;
   localparam logic [7:0] OFF_T8B_CFG = 8'h30;
   localparam logic [7:0] OFF_STATUS = 8'h34;
   localparam logic [7:0] OFF_CLEAR = 8'h38;
   localparam logic [7:0] OFF_IRQ_EN = 8'h3C;
   // field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_EVT_BIT = 1;
   localparam int CTRL_IR_BIT = 2;
   localparam int CH_CAP_BIT = 16;
   localparam int CH_EDGE_LSB = 17;
   localparam int T8_EN_BIT = 0;
   localparam int T8_EVT_BIT = 1;
   localparam int T8_PRESC_LSB = 8;
   localparam int T8_COUNT_LSB = 16;
   localparam int T8_PER_LSB = 0;
   localparam int T8_CMP_LSB = 8;
   localparam int ST_OVF16_BIT = 5;
   localparam int ST_OVF8A_BIT = 6;
   localparam int ST_OVF8B_BIT = 7;
   // reset values
   localparam logic [15:0] PERIOD16_RST = 16'hFFFF;
   localparam logic [7:0] PERIOD8_RST = 8'hFF;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic [7:0] CMP8_RST = 8'h00;

   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } tpci_edge_t;

   typedef struct packed {
      logic en;
      logic evt;
      logic [7:0] presc;
      logic [7:0] period;
      logic [7:0] compare;
   } tpci_t8cfg_t;

   typedef struct packed {
      logic [7:0] count;
      logic pwm;
      logic wrap;
   } tpci_t8out_t;
endpackage

/* File: rtl/tpci_sync.sv */
// two-flop synchronisers with registered edge pulses
`timescale 1ns/1ps
module tpci_sync #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] din_i,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] rise;
      logic [W-1:0] fall;
   } tpci_sync_st_t;

   tpci_sync_st_t s;
   tpci_sync_st_t next_s;

   if (W < 1) begin : g_chk
      $error("tpci_sync needs at least one input");
   end

   // s1 feeds only s2; edges are taken from s2 and s3
   always_comb begin
      next_s = s;
      next_s.s1 = din_i;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.rise = s.s2 & ~s.s3;
      next_s.fall = ~s.s2 & s.s3;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rise_o = s.rise;
   assign fall_o = s.fall;
endmodule // tpci_sync

/* File: rtl/tpci_timer8.sv */
// 8-bit timer with prescaler, period and one pwm compare channel
`timescale 1ns/1ps
module tpci_timer8 (
   input wire logic clk_i,
   input wire logic rst_i,
   input tpci_pkg::tpci_t8cfg_t cfg_i,
   input wire logic evt_i,
   output tpci_pkg::tpci_t8out_t out_o
);
   typedef struct packed {
      logic [7:0] pcnt;
      logic [7:0] cnt;
      logic pwm;
      logic wrap;
   } tpci_t8_st_t;

   tpci_t8_st_t s;
   tpci_t8_st_t next_s;
   logic pre_tick;
   logic tick;

   always_comb begin
      next_s = s;
      next_s.wrap = 1'b0;
      pre_tick = (s.pcnt == cfg_i.presc);
      tick = cfg_i.evt ? evt_i : pre_tick;
      if (!cfg_i.en) begin
         next_s.pcnt = 8'h00;
      end else begin
         next_s.pcnt = pre_tick ? 8'h00 : s.pcnt + 8'h01;
         if (tick) begin
            // >= keeps a shrunk period from running away to 255
            if (s.cnt >= cfg_i.period) begin
               next_s.cnt = 8'h00;
               next_s.wrap = 1'b1;
            end else begin
               next_s.cnt = s.cnt + 8'h01;
            end
         end
      end
      next_s.pwm = cfg_i.en && (next_s.cnt < cfg_i.compare);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign out_o = '{count: s.cnt, pwm: s.pwm, wrap: s.wrap};

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_T8_WRAP: assert property (cfg_i.en && tick && s.cnt == cfg_i.period |=>
      s.wrap && s.cnt == 8'h00)
      else $error("8-bit timer did not wrap at its period");
   AST_T8_PWM: assert property (cfg_i.en && s.cnt == cfg_i.compare |-> !s.pwm)
      else $error("8-bit pwm high at compare match");
   AST_T8_HOLD: assert property (cfg_i.en && !tick |=> $stable(s.cnt))
      else $error("8-bit counter moved without a tick");
endmodule // tpci_timer8

/* File: rtl/tpci_top.sv */
// timer group top: 16-bit pwm/capture timer, two 8-bit timers, ir gating, apb slave
//
// Behaviour
// - The main counter is 16 bits and runs as a free timer, an event counter or a pwm source.
// - The main timer divides the clock by a programmable prescaler and counts to a 16-bit period.
// - The main timer has five channels, each set up on its own with its own 16-bit compare value.
// - Each channel is either a pwm output or a capture that stores the count on input edges.
// - In ir mode the main counter steps once per completed period of the first 8-bit timer.
// - In ir mode the ir output is the and of main channel 0 and the first 8-bit timer's pwm.
// - Two more timers with 8-bit counters each offer timer, counter and pwm operation.
// - Each 8-bit timer divides by a programmable prescaler and counts to an 8-bit period.
// - Each 8-bit timer has one channel with an 8-bit compare value usable as pwm output.
// - Capture inputs pass clocked synchronisers; a pulse must last 1.5 clock periods or more.
`timescale 1ns/1ps
module tpci_top #(
   parameter int NUM_CH = tpci_pkg::CH_N
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [NUM_CH-1:0] CAP_I,
   input wire logic EVT16_I,
   input wire logic [1:0] EVT8_I,
   output logic [NUM_CH-1:0] PWM_O,
   output logic [1:0] T8_PWM_O,
   output logic IR_O,
   output logic IRQ_O
);
   localparam int SYN_W = NUM_CH + 3;
   localparam int SYN_EVT16 = NUM_CH;
   localparam int SYN_EVT8 = NUM_CH + 1;

   typedef struct packed {
      logic en;
      logic evt;
      logic ir;
      logic [7:0] presc;
      logic [7:0] pcnt;
      logic [15:0] period;
      logic [15:0] cnt;
      logic [NUM_CH-1:0][15:0] cmp;
      logic [NUM_CH-1:0] cap;
      logic [NUM_CH-1:0][1:0] edge_sel;
      tpci_pkg::tpci_t8cfg_t [1:0] t8;
      logic [7:0] status;
      logic [7:0] irq_en;
      logic [NUM_CH-1:0] pwm;
      logic ir_out;
      logic irq;
      logic [31:0] prdata;
   } tpci_top_st_t;

   tpci_top_st_t s;
   tpci_top_st_t next_s;
   tpci_pkg::tpci_t8out_t [1:0] t8o;
   logic [SYN_W-1:0] rise;
   logic [SYN_W-1:0] fall;
   logic acc;
   logic wr;
   logic rd_setup;
   logic mapped;
   logic ch_hit;
   int ch_idx;
   logic [31:0] rd;
   logic [7:0] clr;
   logic [7:0] set;
   logic pre_tick;
   logic tick16;
   logic ovf;
   logic [NUM_CH-1:0] cap_ev;

   if (NUM_CH < 1 || NUM_CH > tpci_pkg::CH_N) begin : g_chk
      $error("tpci_top serves one to five channels");
   end

   tpci_sync #(
      .W(SYN_W)
   ) u_sync (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .din_i({EVT8_I, EVT16_I, CAP_I}),
      .rise_o(rise),
      .fall_o(fall)
   );

   for (genvar k = 0; k < 2; k++) begin : g_t8
      tpci_timer8 u_t8 (
         .clk_i(CORE_CLK_I),
         .rst_i(RST_I),
         .cfg_i(s.t8[k]),
         .evt_i(rise[SYN_EVT8+k]),
         .out_o(t8o[k])
      );
   end

   always_comb begin
      next_s = s;
      acc = PSEL_I && PENABLE_I;
      wr = acc && PWRITE_I;
      rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
      ch_hit = 1'b0;
      ch_idx = 0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (PADDR_I == 8'(tpci_pkg::OFF_CH0 + i * tpci_pkg::OFF_CH_STEP)) begin
            ch_hit = 1'b1;
            ch_idx = i;
         end
      end
      mapped = 1'b1;
      rd = 32'h0000_0000;
      clr = 8'h00;
      // address decode: read value and write effect share one chain
      if (PADDR_I == tpci_pkg::OFF_CTRL) begin
         rd[tpci_pkg::CTRL_EN_BIT] = s.en;
         rd[tpci_pkg::CTRL_EVT_BIT] = s.evt;
         rd[tpci_pkg::CTRL_IR_BIT] = s.ir;
         if (wr) begin
            next_s.en = PWDATA_I[tpci_pkg::CTRL_EN_BIT];
            next_s.evt = PWDATA_I[tpci_pkg::CTRL_EVT_BIT];
            next_s.ir = PWDATA_I[tpci_pkg::CTRL_IR_BIT];
         end
      end else if (PADDR_I == tpci_pkg::OFF_PRESC) begin
         rd[7:0] = s.presc;
         if (wr) begin
            next_s.presc = PWDATA_I[7:0];
         end
      end else if (PADDR_I == tpci_pkg::OFF_PERIOD) begin
         rd[15:0] = s.period;
         if (wr) begin
            next_s.period = PWDATA_I[15:0];
         end
      end else if (PADDR_I == tpci_pkg::OFF_COUNT) begin
         rd[15:0] = s.cnt;
      end else if (ch_hit) begin
         rd[15:0] = s.cmp[ch_idx];
         rd[tpci_pkg::CH_CAP_BIT] = s.cap[ch_idx];
         rd[tpci_pkg::CH_EDGE_LSB +: 2] = s.edge_sel[ch_idx];
         if (wr) begin
            next_s.cmp[ch_idx] = PWDATA_I[15:0];
            next_s.cap[ch_idx] = PWDATA_I[tpci_pkg::CH_CAP_BIT];
            next_s.edge_sel[ch_idx] = PWDATA_I[tpci_pkg::CH_EDGE_LSB +: 2];
         end
      end else if (PADDR_I == tpci_pkg::OFF_T8A_CTRL || PADDR_I == tpci_pkg::OFF_T8B_CTRL) begin
         for (int k = 0; k < 2; k++) begin
            if (PADDR_I == (k == 0 ? tpci_pkg::OFF_T8A_CTRL : tpci_pkg::OFF_T8B_CTRL)) begin
               rd[tpci_pkg::T8_EN_BIT] = s.t8[k].en;
               rd[tpci_pkg::T8_EVT_BIT] = s.t8[k].evt;
               rd[tpci_pkg::T8_PRESC_LSB +: 8] = s.t8[k].presc;
               rd[tpci_pkg::T8_COUNT_LSB +: 8] = t8o[k].count;
               if (wr) begin
                  next_s.t8[k].en = PWDATA_I[tpci_pkg::T8_EN_BIT];
                  next_s.t8[k].evt = PWDATA_I[tpci_pkg::T8_EVT_BIT];
                  next_s.t8[k].presc = PWDATA_I[tpci_pkg::T8_PRESC_LSB +: 8];
               end
            end
         end
      end else if (PADDR_I == tpci_pkg::OFF_T8A_CFG || PADDR_I == tpci_pkg::OFF_T8B_CFG) begin
         for (int k = 0; k < 2; k++) begin
            if (PADDR_I == (k == 0 ? tpci_pkg::OFF_T8A_CFG : tpci_pkg::OFF_T8B_CFG)) begin
               rd[tpci_pkg::T8_PER_LSB +: 8] = s.t8[k].period;
               rd[tpci_pkg::T8_CMP_LSB +: 8] = s.t8[k].compare;
               if (wr) begin
                  next_s.t8[k].period = PWDATA_I[tpci_pkg::T8_PER_LSB +: 8];
                  next_s.t8[k].compare = PWDATA_I[tpci_pkg::T8_CMP_LSB +: 8];
               end
            end
         end
      end else if (PADDR_I == tpci_pkg::OFF_STATUS) begin
         rd[7:0] = s.status;
      end else if (PADDR_I == tpci_pkg::OFF_CLEAR) begin
         if (wr) begin
            clr = PWDATA_I[7:0];
         end
      end else if (PADDR_I == tpci_pkg::OFF_IRQ_EN) begin
         rd[7:0] = s.irq_en;
         if (wr) begin
            next_s.irq_en = PWDATA_I[7:0];
         end
      end else begin
         mapped = 1'b0;
      end
      // read data is latched in the setup cycle so it stands through the access cycle
      if (rd_setup) begin
         next_s.prdata = rd;
      end

      // main prescaler and tick source
      pre_tick = (s.pcnt == s.presc);
      next_s.pcnt = s.en ? (pre_tick ? 8'h00 : s.pcnt + 8'h01) : 8'h00;
      if (s.ir) begin
         tick16 = t8o[0].wrap;
      end else if (s.evt) begin
         tick16 = rise[SYN_EVT16];
      end else begin
         tick16 = pre_tick;
      end
      ovf = 1'b0;
      if (s.en && tick16) begin
         if (s.cnt >= s.period) begin
            next_s.cnt = 16'h0000;
            ovf = 1'b1;
         end else begin
            next_s.cnt = s.cnt + 16'h0001;
         end
      end

      // channels: capture overrides a same-cycle software write of the compare value
      cap_ev = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (s.cap[i] && ((s.edge_sel[i][0] && rise[i]) || (s.edge_sel[i][1] && fall[i]))) begin
            next_s.cmp[i] = s.cnt;
            cap_ev[i] = 1'b1;
         end
         next_s.pwm[i] = s.en && !s.cap[i] && (next_s.cnt < s.cmp[i]);
      end

      // a new event beats a clear in the same cycle
      set = 8'h00;
      set[NUM_CH-1:0] = cap_ev;
      set[tpci_pkg::ST_OVF16_BIT] = ovf;
      set[tpci_pkg::ST_OVF8A_BIT] = t8o[0].wrap;
      set[tpci_pkg::ST_OVF8B_BIT] = t8o[1].wrap;
      next_s.status = (s.status & ~clr) | set;
      next_s.irq = |(next_s.status & next_s.irq_en);
      next_s.ir_out = s.ir && s.pwm[0] && t8o[0].pwm;
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         s <= '0;
         s.presc <= tpci_pkg::PRESC_RST;
         s.period <= tpci_pkg::PERIOD16_RST;
         for (int k = 0; k < 2; k++) begin
            s.t8[k].presc <= tpci_pkg::PRESC_RST;
            s.t8[k].period <= tpci_pkg::PERIOD8_RST;
            s.t8[k].compare <= tpci_pkg::CMP8_RST;
         end
      end else begin
         s <= next_s;
      end
   end

   assign PRDATA_O = s.prdata;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = acc && !mapped;
   assign PWM_O = s.pwm;
   assign T8_PWM_O = {t8o[1].pwm, t8o[0].pwm};
   assign IR_O = s.ir_out;
   assign IRQ_O = s.irq;

   localparam int SYNC_LAT_MIN = 1;
   localparam int SYNC_LAT_MAX = 2;

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RST_I);

   sequence seq_wrap_tick;
      s.en && tick16 && s.cnt == s.period;
   endsequence
   sequence seq_cap_rise0;
      s.cap[0] && s.edge_sel[0] == tpci_pkg::EDGE_RISE && rise[0];
   endsequence
   sequence seq_pin_pulse0;
      $rose(CAP_I[0]) ##1 CAP_I[0];
   endsequence

   AST_CNT_WRAP: assert property (seq_wrap_tick |=>
      s.cnt == 16'h0000 && s.status[tpci_pkg::ST_OVF16_BIT])
      else $error("main counter did not wrap with overflow flag");
   AST_CNT_STEP: assert property (s.en && tick16 && s.cnt < s.period |=>
      s.cnt == $past(s.cnt) + 16'h0001)
      else $error("main counter did not step on its tick");
   AST_IR_HOLD: assert property (s.en && s.ir && !t8o[0].wrap |=> $stable(s.cnt))
      else $error("main counter moved in ir mode without an 8-bit period");
   AST_IR_AND: assert property (s.ir |=> IR_O == ($past(s.pwm[0]) && $past(t8o[0].pwm)))
      else $error("ir output is not the and of both pwm outputs");
   AST_CAPTURE: assert property (seq_cap_rise0 |=>
      s.cmp[0] == $past(s.cnt) && s.status[0])
      else $error("capture did not store count and flag");
   AST_SYNC_PULSE: assert property (seq_pin_pulse0 |->
      ##[SYNC_LAT_MIN:SYNC_LAT_MAX] rise[0])
      else $error("held capture pulse not recognised");
   AST_SET_WINS: assert property (wr && PADDR_I == tpci_pkg::OFF_CLEAR && PWDATA_I[0] &&
      cap_ev[0] |=> s.status[0])
      else $error("capture flag lost to a clear");
   AST_PWM_MATCH: assert property (s.en && !s.cap[0] && s.cnt == s.cmp[0] |-> !PWM_O[0])
      else $error("channel pwm high at compare match");
   AST_IRQ: assert property (IRQ_O == |(s.status & s.irq_en))
      else $error("interrupt output disagrees with enabled flags");
   AST_APB_ERR: assert property (acc && !mapped |-> PSLVERR_O && PREADY_O)
      else $error("unmapped access not refused");
endmodule // tpci_top

/* File: tb/tpci_pins.sv */
// pin model of the capture and event sources outside the timer group
`timescale 1ns/1ps
module tpci_pins (
   input wire logic clk_i,
   output logic [7:0] pins_o
);
   // bits 4:0 capture pins, bit 5 main event, bits 7:6 event pins of the 8-bit timers
   initial pins_o = 8'h00;
   // two clocks high: shorter pulses may slip past the synchronisers
   task automatic pulse(input logic [7:0] mask, input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge clk_i);
         pins_o <= mask;
         repeat (2) @(posedge clk_i);
         pins_o <= 8'h00;
         @(posedge clk_i);
      end
      // let the synchroniser and capture stages settle
      repeat (6) @(posedge clk_i);
   endtask
endmodule // tpci_pins

/* File: tb/test_timer_pwm_capture_ir.sv */
// self-checking bench of the timer, pwm, capture and ir block
`timescale 1ns/1ps
module test_timer_pwm_capture_ir;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } tpci_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] pins;
   logic [4:0] pwm;
   logic [1:0] t8;
   logic ir;
   logic irq;
   logic [7:0] obs;
   logic [31:0] q;
   logic e;
   int miscompares = 0;
   int checked = 0;
   int hi [8];
   tpci_row_t rows [16] = '{
      '{1'b0, tpci_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0},
      '{1'b0, tpci_pkg::OFF_PRESC, 32'h0, {24'h0, tpci_pkg::PRESC_RST}, 1'b0},
      '{1'b0, tpci_pkg::OFF_PERIOD, 32'h0, {16'h0, tpci_pkg::PERIOD16_RST}, 1'b0},
      '{1'b0, tpci_pkg::OFF_COUNT, 32'h0, 32'h0, 1'b0},
      '{1'b0, tpci_pkg::OFF_CH0, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h20, 32'h0, 32'h0, 1'b0},
      '{1'b0, tpci_pkg::OFF_T8A_CTRL, 32'h0, 32'h0, 1'b0},
      '{1'b0, tpci_pkg::OFF_T8A_CFG, 32'h0, {16'h0, tpci_pkg::CMP8_RST, tpci_pkg::PERIOD8_RST}, 1'b0},
      '{1'b0, tpci_pkg::OFF_T8B_CFG, 32'h0, {16'h0, tpci_pkg::CMP8_RST, tpci_pkg::PERIOD8_RST}, 1'b0},
      '{1'b0, tpci_pkg::OFF_STATUS, 32'h0, 32'h0, 1'b0},
      '{1'b0, tpci_pkg::OFF_CLEAR, 32'h0, 32'h0, 1'b0},
      '{1'b0, tpci_pkg::OFF_IRQ_EN, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h40, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h40, 32'hFFFFFFFF, 32'h0, 1'b1},
      '{1'b1, tpci_pkg::OFF_PRESC, 32'h55, 32'h0, 1'b0},
      '{1'b0, tpci_pkg::OFF_PRESC, 32'h0, 32'h55, 1'b0}
   };
   assign obs = {ir, t8, pwm};

   tpci_pins pins_model (.clk_i(clk), .pins_o(pins));
   tpci_top DUT (
      .CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .CAP_I(pins[4:0]), .EVT16_I(pins[5]), .EVT8_I(pins[7:6]),
      .PWM_O(pwm), .T8_PWM_O(t8), .IR_O(ir), .IRQ_O(irq)
   );

   initial begin
      forever #20 clk = ~clk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, s, x);
      end
   endtask

   // one apb transfer; read data and error are taken at the edge that sees pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // a slave that never answers is caught by the watchdog
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // wait until output bit b goes from low to high
   task automatic rise(input int b);
      logic p;
      int n;
      for (n = 0; n < 500; n++) begin
         p = obs[b];
         @(posedge clk);
         if (p === 1'b0 && obs[b] === 1'b1) break;
      end
      if (n == 500) begin
         miscompares++;
         tally_and_finish();
      end
   endtask

   // high cycles of every pwm and ir output over one window
   task automatic meas(input int n);
      foreach (hi[b]) hi[b] = 0;
      repeat (n) begin
         @(posedge clk);
         foreach (hi[b]) hi[b] += (obs[b] === 1'b1) ? 1 : 0;
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      chk({24'h0, obs}, 32'h0);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         chk({31'h0, e}, {31'h0, rows[i].e});
         if (!rows[i].wr) chk(q, rows[i].x);
      end
      $display("test register map done");
      // divide by 4, period 9: one pwm period is 40 clocks, channel i high 4*(i+1)
      apb(1'b1, tpci_pkg::OFF_PRESC, 32'h3);
      apb(1'b1, tpci_pkg::OFF_PERIOD, 32'h9);
      for (int i = 0; i < 5; i++) apb(1'b1, tpci_pkg::OFF_CH0 + 8'(4 * i), 32'(i + 1));
      apb(1'b1, tpci_pkg::OFF_CTRL, 32'h1);
      rise(0);
      meas(40);
      for (int i = 0; i < 5; i++) chk(32'(hi[i]), 32'(4 * (i + 1)));
      apb(1'b1, tpci_pkg::OFF_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      chk({27'h0, pwm}, 32'h0);
      apb(1'b0, tpci_pkg::OFF_STATUS, 32'h0);
      chk(q & 32'h20, 32'h20);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, tpci_pkg::OFF_IRQ_EN, 32'h20);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, tpci_pkg::OFF_CLEAR, 32'h20);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, tpci_pkg::OFF_STATUS, 32'h0);
      chk(q, 32'h0);
      $display("test main pwm and overflow done");
      // reset in mid-run, then count five events and capture on edges
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk({24'h0, obs}, 32'h0);
      apb(1'b1, tpci_pkg::OFF_CTRL, 32'h3);
      apb(1'b1, tpci_pkg::OFF_CH0, 32'h30000);
      apb(1'b1, 8'h18, 32'h30000);
      apb(1'b1, 8'h1C, 32'h50000);
      apb(1'b1, 8'h20, 32'h10000);
      pins_model.pulse(8'h20, 5);
      pins_model.pulse(8'h1D, 1);
      chk({27'h0, pwm}, 32'h0);
      apb(1'b1, tpci_pkg::OFF_COUNT, 32'h0);
      apb(1'b0, tpci_pkg::OFF_COUNT, 32'h0);
      chk(q, 32'h5);
      apb(1'b0, tpci_pkg::OFF_CH0, 32'h0);
      chk(q & 32'hFFFF, 32'h5);
      apb(1'b0, 8'h18, 32'h0);
      chk(q & 32'hFFFF, 32'h5);
      apb(1'b0, 8'h1C, 32'h0);
      chk(q & 32'hFFFF, 32'h5);
      apb(1'b0, 8'h20, 32'h0);
      chk(q & 32'hFFFF, 32'h0);
      apb(1'b0, tpci_pkg::OFF_STATUS, 32'h0);
      chk(q, 32'h0D);
      // the clear of bits 2 and 0 lands in the cycle of a new channel 0 capture
      fork
         pins_model.pulse(8'h01, 1);
         begin
            repeat (2) @(posedge clk);
            apb(1'b1, tpci_pkg::OFF_CLEAR, 32'h5);
         end
      join
      apb(1'b0, tpci_pkg::OFF_STATUS, 32'h0);
      chk(q, 32'h09);
      $display("test capture done");
      // timer A: divide by 2, period 4, compare 2; main steps on its wraps, period 3
      apb(1'b1, tpci_pkg::OFF_T8A_CFG, 32'h0204);
      apb(1'b1, tpci_pkg::OFF_T8A_CTRL, 32'h0101);
      apb(1'b1, tpci_pkg::OFF_T8B_CTRL, 32'h3);
      apb(1'b1, tpci_pkg::OFF_T8B_CFG, 32'h05FF);
      apb(1'b1, tpci_pkg::OFF_PERIOD, 32'h3);
      apb(1'b1, tpci_pkg::OFF_CH0, 32'h2);
      apb(1'b1, tpci_pkg::OFF_CTRL, 32'h5);
      pins_model.pulse(8'h80, 3);
      apb(1'b0, tpci_pkg::OFF_T8B_CTRL, 32'h0);
      chk((q >> 16) & 32'hFF, 32'h3);
      rise(0);
      meas(40);
      chk(32'(hi[0]), 32'd20);
      chk(32'(hi[5]), 32'd16);
      chk(32'(hi[6]), 32'd40);
      chk(32'(hi[7]), 32'd8);
      apb(1'b0, tpci_pkg::OFF_STATUS, 32'h0);
      chk(q & 32'h40, 32'h40);
      $display("test 8-bit timers and ir done");
      tally_and_finish();
   end
endmodule // test_timer_pwm_capture_ir
